/* File: design/rif_pkg.sv */
// Constants and types for the receive indicator frame builder
package rif_pkg;
  localparam logic [7:0] RIF_DELIM = 8'h7e;
  localparam logic [7:0] RIF_TYPE_EXPL = 8'h91;
  localparam logic [7:0] RIF_TYPE_IO = 8'h92;
  localparam logic [7:0] RIF_TYPE_NODE = 8'h95;
  localparam logic [7:0] RIF_CSUM_BASE = 8'hff;
  localparam logic [7:0] RIF_SAMPLE_SETS = 8'h01;
  localparam logic [15:0] RIF_RSVD_NET = 16'hfffe;
  localparam logic [7:0] RIF_AMASK_VALID = 8'h8f;
  localparam logic [2:0] RIF_SUPPLY_CH = 3'h7;
  localparam int RIF_ANA_CH = 5;
  // Packet kinds offered on the receive side
  localparam logic [1:0] RIF_KIND_IO = 2'h0;
  localparam logic [1:0] RIF_KIND_DATA = 2'h1;
  localparam logic [1:0] RIF_KIND_NODE = 2'h2;
  // Header positions, counted from the type byte (frame offset 3)
  localparam logic [4:0] RIF_POS_TYPE = 5'h00;
  localparam logic [4:0] RIF_POS_ADDR_LAST = 5'h08;
  localparam logic [4:0] RIF_POS_NET_HI = 5'h09;
  localparam logic [4:0] RIF_POS_NET_LO = 5'h0a;
  localparam logic [4:0] RIF_POS_B11 = 5'h0b;
  localparam logic [4:0] RIF_POS_B12 = 5'h0c;
  localparam logic [4:0] RIF_POS_B13 = 5'h0d;
  localparam logic [4:0] RIF_POS_B14 = 5'h0e;
  localparam logic [4:0] RIF_POS_B15 = 5'h0f;
  localparam logic [4:0] RIF_POS_B16 = 5'h10;
  localparam logic [4:0] RIF_POS_B17 = 5'h11;
  localparam logic [4:0] RIF_LAST_IO = 5'h0f;
  localparam logic [4:0] RIF_LAST_EXPL = 5'h11;
  localparam logic [4:0] RIF_LAST_NODE = 5'h0b;
  localparam logic [15:0] RIF_LEN_IO = 16'h0010;
  localparam logic [15:0] RIF_LEN_EXPL = 16'h0012;
  localparam logic [15:0] RIF_LEN_NODE = 16'h000c;
  localparam logic [15:0] RIF_LEN_DIG = 16'h0002;

  typedef enum {
    RIF_ST_IDLE, RIF_ST_DELIM, RIF_ST_LEN_HI, RIF_ST_LEN_LO, RIF_ST_HDR,
    RIF_ST_DIG, RIF_ST_ANA, RIF_ST_PAY, RIF_ST_CSUM, RIF_ST_DROP
  } rif_state_t;
endpackage

/* File: design/rif_frame_builder.sv */
// Receive indicator frame builder with its output FIFO
`timescale 1ns/1ps
`default_nettype none

module rif_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// Behaviour
// (RULE1) IO sample with explicit setting: type 0x92
// (RULE2) Sender 64-bit address, MSB first, offsets 4-11
// (RULE3) Sender network address at 12-13, MSB first
// (RULE4) Options byte: 0x01 acked, 0x02 broadcast
// (RULE5) Host ignores other option bits
// (RULE6) Sample-set count at 15 is always one
// (RULE7) Digital channel mask at 16-17
// (RULE8) Analog channel mask at 18
// (RULE9) Digital samples at 19-20 only if mask nonzero
// (RULE10) Disabled digital lines read zero
// (RULE11) Digital sample bits match mask bits
// (RULE12) Each enabled analog input: two bytes from 21
// (RULE13) Analog order: inputs 0-3, then supply
// (RULE14) Data with explicit setting: 0x91 frame
// (RULE15) Node id with setting zero: 0x95 frame
// (RULE16) Explicit layout: endpoints, cluster, profile, options
// (RULE17) Delimiter 0x7e then big-endian length
// (RULE18) Checksum is 0xff minus byte sum
module rif_frame_builder
  import rif_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic api_output_format_select,
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire logic [1:0] pkt_kind,
  input wire logic [63:0] pkt_src_addr,
  input wire logic [15:0] pkt_net_addr,
  input wire logic pkt_acked,
  input wire logic pkt_bcast,
  input wire logic [15:0] pkt_dig_mask,
  input wire logic [7:0] pkt_ana_mask,
  input wire logic [15:0] pkt_dig_samples,
  input wire logic [16*RIF_ANA_CH-1:0] pkt_ana_values,
  input wire logic [7:0] pkt_src_ep,
  input wire logic [7:0] pkt_dst_ep,
  input wire logic [15:0] pkt_cluster,
  input wire logic [15:0] pkt_profile,
  input wire logic [15:0] pkt_pay_len,
  input wire logic pay_valid,
  output logic pay_ready,
  input wire logic [7:0] pay_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last
);
  function automatic logic [15:0] pair_count(input logic [7:0] m);
    logic [15:0] n;
    n = '0;
    for (int i = 0; i < 8; i++) begin
      n = n + {15'h0000, m[i]};
    end
    return n;
  endfunction

  function automatic logic [2:0] lowest_ch(input logic [7:0] m);
    logic [2:0] c;
    c = RIF_SUPPLY_CH;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        c = 3'(i);
      end
    end
    return c;
  endfunction

  // Format pin comes from outside the clock domain
  logic fmt_meta, fmt_sync;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fmt_meta <= 1'b0;
      fmt_sync <= 1'b0;
    end else begin
      fmt_meta <= api_output_format_select;
      fmt_sync <= fmt_meta;
    end
  end

  rif_state_t state, next_state;
  logic [1:0] kind, next_kind;
  logic [63:0] src_addr, next_src_addr;
  logic [15:0] net_addr, next_net_addr;
  logic [7:0] opts, next_opts;
  logic [15:0] dmask, next_dmask;
  logic [7:0] amask, next_amask;
  logic [15:0] dsamp, next_dsamp;
  logic [16*RIF_ANA_CH-1:0] avals, next_avals;
  logic [7:0] sep, next_sep, dep, next_dep;
  logic [15:0] cluster, next_cluster, profile, next_profile;
  logic [15:0] len, next_len, remain, next_remain;
  logic [4:0] pos, next_pos;
  logic half, next_half;
  logic [7:0] sum, next_sum;

  logic f_valid, f_ready, f_last;
  logic [7:0] f_byte, hdr_byte, ana_byte;
  logic [4:0] hdr_last;
  logic [2:0] ach, aidx;
  logic [15:0] aword;
  logic accept, push, do_emit;

  assign pkt_ready = (state == RIF_ST_IDLE);
  assign accept = pkt_valid && pkt_ready;
  assign push = f_valid && f_ready;

  always_comb begin
    unique case (kind)
      RIF_KIND_IO: hdr_last = RIF_LAST_IO;
      RIF_KIND_DATA: hdr_last = RIF_LAST_EXPL;
      default: hdr_last = RIF_LAST_NODE;
    endcase
  end

  // Header bytes from the type byte onward
  always_comb begin
    hdr_byte = 8'h00;
    if (pos == RIF_POS_TYPE) begin
      unique case (kind)
        RIF_KIND_IO: hdr_byte = RIF_TYPE_IO; // RULE1
        RIF_KIND_DATA: hdr_byte = RIF_TYPE_EXPL; // RULE14
        default: hdr_byte = RIF_TYPE_NODE; // RULE15
      endcase
    end else if (pos <= RIF_POS_ADDR_LAST) begin
      hdr_byte = src_addr[8*(8-32'(pos)) +: 8]; // RULE2
    end else if (pos == RIF_POS_NET_HI) begin
      hdr_byte = (kind == RIF_KIND_IO) ? net_addr[15:8]
                                      : RIF_RSVD_NET[15:8]; // RULE3
    end else if (pos == RIF_POS_NET_LO) begin
      hdr_byte = (kind == RIF_KIND_IO) ? net_addr[7:0]
                                      : RIF_RSVD_NET[7:0]; // RULE3
    end else if (kind == RIF_KIND_DATA) begin
      unique case (pos)
        RIF_POS_B11: hdr_byte = sep; // RULE16
        RIF_POS_B12: hdr_byte = dep; // RULE16
        RIF_POS_B13: hdr_byte = cluster[15:8]; // RULE16
        RIF_POS_B14: hdr_byte = cluster[7:0];
        RIF_POS_B15: hdr_byte = profile[15:8]; // RULE16
        RIF_POS_B16: hdr_byte = profile[7:0];
        RIF_POS_B17: hdr_byte = opts; // RULE16
        default: hdr_byte = 8'h00;
      endcase
    end else begin
      unique case (pos)
        RIF_POS_B11: hdr_byte = opts; // RULE4
        RIF_POS_B12: hdr_byte = RIF_SAMPLE_SETS; // RULE6
        RIF_POS_B13: hdr_byte = dmask[15:8]; // RULE7
        RIF_POS_B14: hdr_byte = dmask[7:0]; // RULE7
        RIF_POS_B15: hdr_byte = amask; // RULE8
        default: hdr_byte = 8'h00;
      endcase
    end
  end

  // Supply reading sits after the four inputs
  assign ach = lowest_ch(amask);
  assign aidx = (ach == RIF_SUPPLY_CH) ? 3'(RIF_ANA_CH - 1) : ach;
  assign aword = avals[16*32'(aidx) +: 16]; // RULE13
  assign ana_byte = half ? aword[7:0] : aword[15:8]; // RULE12

  always_comb begin
    f_valid = 1'b0;
    f_byte = 8'h00;
    f_last = 1'b0;
    pay_ready = 1'b0;
    unique case (state)
      RIF_ST_DELIM: begin
        f_valid = 1'b1;
        f_byte = RIF_DELIM; // RULE17
      end
      RIF_ST_LEN_HI: begin
        f_valid = 1'b1;
        f_byte = len[15:8]; // RULE17
      end
      RIF_ST_LEN_LO: begin
        f_valid = 1'b1;
        f_byte = len[7:0]; // RULE17
      end
      RIF_ST_HDR: begin
        f_valid = 1'b1;
        f_byte = hdr_byte;
      end
      RIF_ST_DIG: begin
        f_valid = 1'b1;
        f_byte = half ? dsamp[7:0] : dsamp[15:8]; // RULE11
      end
      RIF_ST_ANA: begin
        f_valid = 1'b1;
        f_byte = ana_byte;
      end
      RIF_ST_PAY: begin
        f_valid = pay_valid;
        f_byte = pay_data;
        pay_ready = f_ready;
      end
      RIF_ST_CSUM: begin
        f_valid = 1'b1;
        f_byte = RIF_CSUM_BASE - sum; // RULE18
        f_last = 1'b1;
      end
      RIF_ST_DROP: pay_ready = 1'b1;
      default: ;
    endcase
  end

  assign do_emit = (kind == RIF_KIND_NODE) ? !fmt_sync : fmt_sync;

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_src_addr = src_addr;
    next_net_addr = net_addr;
    next_opts = opts;
    next_dmask = dmask;
    next_amask = amask;
    next_dsamp = dsamp;
    next_avals = avals;
    next_sep = sep;
    next_dep = dep;
    next_cluster = cluster;
    next_profile = profile;
    next_len = len;
    next_remain = remain;
    next_pos = pos;
    next_half = half;
    next_sum = sum;
    if (push && state != RIF_ST_DELIM && state != RIF_ST_LEN_HI
        && state != RIF_ST_LEN_LO) begin
      next_sum = sum + f_byte; // RULE18
    end
    unique case (state)
      RIF_ST_IDLE: begin
        if (accept) begin
          next_kind = pkt_kind;
          next_src_addr = pkt_src_addr;
          next_net_addr = pkt_net_addr;
          next_opts = {6'h00, pkt_bcast, pkt_acked}; // RULE4
          next_dmask = pkt_dig_mask;
          next_amask = pkt_ana_mask & RIF_AMASK_VALID;
          next_dsamp = pkt_dig_samples & pkt_dig_mask; // RULE10
          next_avals = pkt_ana_values;
          next_sep = pkt_src_ep;
          next_dep = pkt_dst_ep;
          next_cluster = pkt_cluster;
          next_profile = pkt_profile;
          next_remain = pkt_pay_len;
          next_pos = RIF_POS_TYPE;
          next_half = 1'b0;
          next_sum = 8'h00;
          unique case (pkt_kind)
            RIF_KIND_IO: next_len = RIF_LEN_IO
              + ((pkt_dig_mask != '0) ? RIF_LEN_DIG : 16'h0000)
              + (pair_count(pkt_ana_mask & RIF_AMASK_VALID) << 1);
            RIF_KIND_DATA: next_len = RIF_LEN_EXPL + pkt_pay_len;
            default: next_len = RIF_LEN_NODE + pkt_pay_len;
          endcase
          next_state = RIF_ST_DROP;
          if ((pkt_kind == RIF_KIND_NODE) ? !fmt_sync : fmt_sync) begin
            next_state = RIF_ST_DELIM; // RULE1
          end
        end
      end
      RIF_ST_DELIM: if (push) next_state = RIF_ST_LEN_HI;
      RIF_ST_LEN_HI: if (push) next_state = RIF_ST_LEN_LO;
      RIF_ST_LEN_LO: if (push) next_state = RIF_ST_HDR;
      RIF_ST_HDR: begin
        if (push) begin
          next_pos = pos + 5'h01;
          if (pos == hdr_last) begin
            if (kind != RIF_KIND_IO) begin
              next_state = (remain != '0) ? RIF_ST_PAY : RIF_ST_CSUM;
            end else if (dmask != '0) begin
              next_state = RIF_ST_DIG; // RULE9
            end else if (amask != '0) begin
              next_state = RIF_ST_ANA; // RULE12
            end else begin
              next_state = RIF_ST_CSUM;
            end
          end
        end
      end
      RIF_ST_DIG: begin
        if (push) begin
          next_half = !half;
          if (half) begin
            next_state = (amask != '0) ? RIF_ST_ANA : RIF_ST_CSUM;
          end
        end
      end
      RIF_ST_ANA: begin
        if (push) begin
          next_half = !half;
          if (half) begin
            next_amask = amask & ~(8'h01 << ach); // RULE13
            if ((amask & ~(8'h01 << ach)) == '0) begin
              next_state = RIF_ST_CSUM;
            end
          end
        end
      end
      RIF_ST_PAY: begin
        if (push) begin
          next_remain = remain - 16'h0001;
          if (remain == 16'h0001) begin
            next_state = RIF_ST_CSUM;
          end
        end
      end
      RIF_ST_CSUM: if (push) next_state = RIF_ST_IDLE;
      RIF_ST_DROP: begin
        // Discarded packets still drain their payload
        if (remain == '0) begin
          next_state = RIF_ST_IDLE;
        end else if (pay_valid) begin
          next_remain = remain - 16'h0001;
        end
      end
      default: next_state = RIF_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= RIF_ST_IDLE;
      kind <= RIF_KIND_IO;
      src_addr <= '0;
      net_addr <= '0;
      opts <= '0;
      dmask <= '0;
      amask <= '0;
      dsamp <= '0;
      avals <= '0;
      sep <= '0;
      dep <= '0;
      cluster <= '0;
      profile <= '0;
      len <= '0;
      remain <= '0;
      pos <= '0;
      half <= 1'b0;
      sum <= '0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      src_addr <= next_src_addr;
      net_addr <= next_net_addr;
      opts <= next_opts;
      dmask <= next_dmask;
      amask <= next_amask;
      dsamp <= next_dsamp;
      avals <= next_avals;
      sep <= next_sep;
      dep <= next_dep;
      cluster <= next_cluster;
      profile <= next_profile;
      len <= next_len;
      remain <= next_remain;
      pos <= next_pos;
      half <= next_half;
      sum <= next_sum;
    end
  end

  // Four words absorb short host stalls without holding the builder
  rif_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data({f_last, f_byte}),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data({tx_last, tx_data})
  );

  sequence s_accept_emit;
    accept && ((pkt_kind == RIF_KIND_NODE) ? !fmt_sync : fmt_sync);
  endsequence
  sequence s_delim_out;
    state == RIF_ST_DELIM && f_byte == RIF_DELIM;
  endsequence

  a_frame_start: assert property ( // RULE17
    @(posedge ref_clk) disable iff (rst) s_accept_emit |=> s_delim_out)
    else $error("frame does not open with delimiter");
  a_io_type: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    push && state == RIF_ST_HDR && pos == RIF_POS_TYPE
    && kind == RIF_KIND_IO |-> f_byte == RIF_TYPE_IO)
    else $error("sample frame type wrong");
  a_fmt_gate: assert property (@(posedge ref_clk) disable iff (rst) // RULE15
    state == RIF_ST_HDR |-> do_emit || $past(do_emit))
    else $error("frame built against format setting");
  a_sample_count: assert property ( // RULE6
    @(posedge ref_clk) disable iff (rst)
    push && state == RIF_ST_HDR && kind == RIF_KIND_IO
    && pos == RIF_POS_B12 |-> f_byte == RIF_SAMPLE_SETS)
    else $error("sample set count not one");
  a_dig_skip: assert property (@(posedge ref_clk) disable iff (rst) // RULE9
    state == RIF_ST_DIG |-> dmask != '0)
    else $error("digital bytes with empty mask");
  a_dig_zero: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
    state != RIF_ST_IDLE |-> (dsamp & ~dmask) == '0)
    else $error("disabled digital line not zero");
  a_ana_pair: assert property (@(posedge ref_clk) disable iff (rst) // RULE12
    push && state == RIF_ST_ANA && !half |=> state == RIF_ST_ANA)
    else $error("analog value split");
  a_csum_last: assert property (@(posedge ref_clk) disable iff (rst) // RULE18
    push && state == RIF_ST_CSUM |-> f_last
    && f_byte + sum == RIF_CSUM_BASE)
    else $error("checksum wrong");
endmodule

`default_nettype wire

/* File: verif/rif_host_model.sv */
// Host controller model that takes the output byte stream
`timescale 1ns/1ps
`default_nettype none

module rif_host_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  logic [8:0] rx_q[$];
  logic [1:0] ph;

  // While stall is high, host takes one byte in three, so the FIFO fills
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      tx_ready <= !stall || (ph == 2'h1);
    end
  end

  // Raw capture; option bits past ack and broadcast never read
  always @(posedge ref_clk) begin
    if (!rst && tx_valid && tx_ready) begin
      rx_q.push_back({tx_last, tx_data});
    end
  end
endmodule

`default_nettype wire

/* File: verif/tb.sv */
// Self-checking testbench for the receive indicator frame builder
`timescale 1ns/1ps
`default_nettype none

module tb
  import rif_pkg::*;
;
  logic ref_clk, rst, fmt, pkt_valid, pkt_ready, pkt_acked, pkt_bcast;
  logic pay_valid, pay_ready, tx_valid, tx_ready, tx_last, stall;
  logic [1:0] pkt_kind;
  logic [63:0] pkt_src_addr;
  logic [15:0] pkt_net_addr, pkt_dig_mask, pkt_dig_samples, pkt_cluster;
  logic [15:0] pkt_profile, pkt_pay_len;
  logic [7:0] pkt_ana_mask, pkt_src_ep, pkt_dst_ep, pay_data, tx_data;
  logic [16*RIF_ANA_CH-1:0] pkt_ana_values;
  logic [7:0] pay_q[$], body[$];
  logic [8:0] exp_s[$];
  int bad_count, checks, cyc;

  rif_frame_builder #(.FIFO_DEPTH(4)) u_dut (
    .ref_clk, .rst, .api_output_format_select(fmt), .pkt_valid,
    .pkt_ready, .pkt_kind, .pkt_src_addr, .pkt_net_addr, .pkt_acked,
    .pkt_bcast, .pkt_dig_mask, .pkt_ana_mask, .pkt_dig_samples,
    .pkt_ana_values, .pkt_src_ep, .pkt_dst_ep, .pkt_cluster, .pkt_profile,
    .pkt_pay_len, .pay_valid, .pay_ready, .pay_data, .tx_valid, .tx_ready,
    .tx_data, .tx_last
  );

  rif_host_model u_host (
    .ref_clk, .rst, .stall, .tx_valid, .tx_ready, .tx_data, .tx_last
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run needs under a thousand cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic cmp9(string what, logic [8:0] exp, logic [8:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_int(string what, int exp, int got);
    checks++;
    if (got != exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic set_fmt(logic v);
    fmt <= v;
    // Two sync flops before the setting is seen
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic set_hdr(logic [1:0] k, logic [63:0] a, logic ack, logic bc);
    pkt_kind <= k;
    pkt_src_addr <= a;
    pkt_acked <= ack;
    pkt_bcast <= bc;
    pay_q.delete();
  endtask

  task automatic set_io(logic [15:0] dm, logic [7:0] am, logic [15:0] ds);
    pkt_dig_mask <= dm;
    pkt_ana_mask <= am;
    pkt_dig_samples <= ds;
  endtask

  // Request held until taken; payload bytes follow one by one
  task automatic send();
    pkt_pay_len <= 16'(pay_q.size());
    pkt_valid <= 1'b1;
    @(negedge ref_clk);
    while (!pkt_ready) @(negedge ref_clk);
    @(posedge ref_clk);
    pkt_valid <= 1'b0;
    foreach (pay_q[i]) begin
      pay_valid <= 1'b1;
      pay_data <= pay_q[i];
      @(negedge ref_clk);
      while (!pay_ready) @(negedge ref_clk);
      @(posedge ref_clk);
    end
    pay_valid <= 1'b0;
    // One edge passes so a following call never re-raises valid at once
    @(posedge ref_clk);
  endtask

  task automatic push16(logic [15:0] v);
    body.push_back(v[15:8]);
    body.push_back(v[7:0]);
  endtask

  task automatic hdr(logic [7:0] t);
    body.push_back(t);
    for (int i = 7; i >= 0; i--) body.push_back(pkt_src_addr[8*i +: 8]);
  endtask

  task automatic close_frame();
    logic [7:0] sum;
    sum = 8'h00;
    foreach (body[i]) sum += body[i];
    exp_s.push_back({1'b0, RIF_DELIM});
    exp_s.push_back({1'b0, 8'(body.size() >> 8)});
    exp_s.push_back({1'b0, 8'(body.size())});
    foreach (body[i]) exp_s.push_back({1'b0, body[i]});
    exp_s.push_back({1'b1, RIF_CSUM_BASE - sum});
    body.delete();
  endtask

  task automatic exp_io();
    hdr(RIF_TYPE_IO);
    push16(pkt_net_addr);
    body.push_back({6'h00, pkt_bcast, pkt_acked});
    body.push_back(RIF_SAMPLE_SETS);
    push16(pkt_dig_mask);
    body.push_back(pkt_ana_mask & RIF_AMASK_VALID);
    if (pkt_dig_mask != 16'h0000) begin
      push16(pkt_dig_samples & pkt_dig_mask);
    end
    for (int c = 0; c < 4; c++) begin
      if (pkt_ana_mask[c]) push16(pkt_ana_values[16*c +: 16]);
    end
    if (pkt_ana_mask[7]) push16(pkt_ana_values[79:64]);
    close_frame();
  endtask

  task automatic exp_pay(logic [7:0] t);
    hdr(t);
    push16(RIF_RSVD_NET);
    if (t == RIF_TYPE_EXPL) begin
      body.push_back(pkt_src_ep);
      body.push_back(pkt_dst_ep);
      push16(pkt_cluster);
      push16(pkt_profile);
    end
    body.push_back({6'h00, pkt_bcast, pkt_acked});
    foreach (pay_q[i]) body.push_back(pay_q[i]);
    close_frame();
  endtask

  task automatic check_stream();
    int quiet;
    quiet = 0;
    while (quiet < 8) begin
      @(negedge ref_clk);
      quiet = (pkt_ready && !tx_valid) ? quiet + 1 : 0;
    end
    @(posedge ref_clk);
    cmp_int("byte count", exp_s.size(), u_host.rx_q.size());
    foreach (exp_s[i]) begin
      if (i < u_host.rx_q.size()) begin
        cmp9($sformatf("byte %0d", i), exp_s[i], u_host.rx_q[i]);
      end
    end
    exp_s.delete();
    u_host.rx_q.delete();
  endtask

  // Sample frame with stray digital bits outside the mask
  task automatic t_io_digital();
    set_hdr(RIF_KIND_IO, 64'h0123456789abcdef, 1'b1, 1'b0);
    set_io(16'h001c, 8'h02, 16'h8035);
    pkt_net_addr <= 16'h5a3c;
    pkt_ana_values <= {16'h0bad, 16'h0777, 16'h0666, 16'h0225, 16'h0555};
    send();
    exp_io();
    check_stream();
  endtask

  // Back-to-back frames into a slow host: all analog, then no analog
  task automatic t_io_back2back();
    stall <= 1'b1;
    set_hdr(RIF_KIND_IO, 64'hfedcba9876543210, 1'b0, 1'b1);
    set_io(16'h0000, 8'hff, 16'hffff);
    pkt_ana_values <= {16'h0305, 16'h0304, 16'h0203, 16'h0102, 16'h0001};
    send();
    exp_io();
    set_hdr(RIF_KIND_IO, 64'h8000000000000001, 1'b1, 1'b1);
    set_io(16'hffff, 8'h00, 16'ha55a);
    send();
    exp_io();
    check_stream();
    stall <= 1'b0;
  endtask

  // Explicit frame with payload, then one with no payload
  task automatic t_explicit();
    set_hdr(RIF_KIND_DATA, 64'h1122334455667788, 1'b0, 1'b1);
    pkt_src_ep <= 8'he0;
    pkt_dst_ep <= 8'he1;
    pkt_cluster <= 16'h2211;
    pkt_profile <= 16'h4d2a;
    pay_q = '{8'h52, 8'h78, 8'h44, 8'h61, 8'h74, 8'h61};
    send();
    exp_pay(RIF_TYPE_EXPL);
    set_hdr(RIF_KIND_DATA, 64'h0000000000000000, 1'b1, 1'b0);
    send();
    exp_pay(RIF_TYPE_EXPL);
    check_stream();
  endtask

  // Packets the current setting does not forward leave no output
  task automatic t_drops();
    set_fmt(1'b0);
    set_hdr(RIF_KIND_IO, 64'h0101010101010101, 1'b1, 1'b0);
    send();
    set_hdr(RIF_KIND_DATA, 64'h0202020202020202, 1'b1, 1'b0);
    pay_q = '{8'h10, 8'h20, 8'h30};
    send();
    check_stream();
    set_fmt(1'b1);
    set_hdr(RIF_KIND_NODE, 64'h0303030303030303, 1'b0, 1'b1);
    pay_q = '{8'h40, 8'h50};
    send();
    check_stream();
  endtask

  // Node identification forwarded only with the setting at zero
  task automatic t_node();
    set_fmt(1'b0);
    stall <= 1'b1;
    set_hdr(RIF_KIND_NODE, 64'h0a0b0c0d0e0f1011, 1'b1, 1'b1);
    pay_q = '{8'hff, 8'hfe, 8'h20, 8'h00, 8'h01, 8'h01, 8'h9c};
    send();
    exp_pay(RIF_TYPE_NODE);
    check_stream();
    stall <= 1'b0;
    set_fmt(1'b1);
  endtask

  initial begin
    rst = 1'b1;
    fmt = 1'b1;
    stall = 1'b0;
    pkt_valid = 1'b0;
    pkt_kind = 2'h0;
    pkt_src_addr = 64'h0;
    pkt_net_addr = 16'h0;
    pkt_acked = 1'b0;
    pkt_bcast = 1'b0;
    pkt_dig_mask = 16'h0;
    pkt_ana_mask = 8'h0;
    pkt_dig_samples = 16'h0;
    pkt_ana_values = '0;
    pkt_src_ep = 8'h0;
    pkt_dst_ep = 8'h0;
    pkt_cluster = 16'h0;
    pkt_profile = 16'h0;
    pkt_pay_len = 16'h0;
    pay_valid = 1'b0;
    pay_data = 8'h0;
    bad_count = 0;
    checks = 0;
    cyc = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    t_io_digital();
    t_io_back2back();
    t_explicit();
    t_drops();
    t_node();
    t_explicit();
    final_report();
  end
endmodule

`default_nettype wire
